// ### rtl/dram_ctrl.sv
`timescale 1ns/10ps
module dram_ctrl
  import dram_ctrl_pkg::*;
#(
  parameter int RefreshGap = RefreshGapDefault,
  parameter int CntWidth = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clkEn,
  // User request
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqWrite,
  input wire logic [AddrWidth-1:0] reqAddr,
  input wire logic reqData,
  output logic rdValid,
  output logic rdData,
  // Memory pins
  output logic rowStrobe,
  output logic colStrobeN,
  output logic writeN,
  output logic chipSelN,
  output logic [HalfWidth-1:0] memAddr,
  output logic memDin,
  input wire logic memDout,
  input wire logic memDoutOe
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_ROW, ST_COL, ST_HOLD, ST_PRECH
  } state_t;

  localparam logic [CntWidth-1:0] RowPrechC = CntWidth'(RowPrechCyc);
  localparam logic [CntWidth-1:0] LeadC = CntWidth'(LeadCyc);
  localparam logic [CntWidth-1:0] ColC = CntWidth'(ColWidthCyc);
  localparam logic [CntWidth-1:0] AccC = CntWidth'(AccessCyc);
  localparam logic [CntWidth-1:0] GapC = CntWidth'(RefreshGap);
  localparam logic [CntWidth-1:0] OffC = CntWidth'(OffCyc);
  localparam logic [CntWidth-1:0] CycC = CntWidth'(CycleCyc);

  state_t state_reg, state_next;
  logic [CntWidth-1:0] cnt_reg, cnt_next;
  logic [CntWidth-1:0] refCnt_reg, refCnt_next;
  logic [HalfWidth-1:0] refRow_reg, refRow_next;
  logic [AddrWidth-1:0] addr_reg, addr_next;
  logic wr_reg, wr_next, din_reg, din_next;
  logic refr_reg, refr_next, dummy_reg, dummy_next;
  logic rdValid_reg, rdValid_next, rdData_reg, rdData_next;
  logic [CntWidth-1:0] rowCnt_reg, rowCnt_next;
  logic [CntWidth-1:0] sinceRise_reg, sinceRise_next;

  // Cycle sequencer next state
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    refCnt_next = (refCnt_reg == GapC) ? refCnt_reg : refCnt_reg + 1'b1;
    refRow_next = refRow_reg;
    addr_next = addr_reg;
    wr_next = wr_reg;
    din_next = din_reg;
    refr_next = refr_reg;
    dummy_next = dummy_reg;
    rdValid_next = 1'b0;
    rdData_next = rdData_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (refCnt_reg == GapC) begin
          // Refresh has priority; row-only cycle
          refr_next = 1'b1;
          addr_next = {refRow_reg, {HalfWidth{1'b0}}};
          refRow_next = refRow_reg + 1'b1;
          refCnt_next = '0;
          state_next = ST_ROW;
          cnt_next = '0;
        end else if (reqValid) begin
          refr_next = 1'b0;
          addr_next = reqAddr; // Whole 12-bit word address
          wr_next = reqWrite & ~dummy_reg;
          din_next = reqData;
          state_next = ST_ROW;
          cnt_next = '0;
        end
      end
      ST_ROW: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg + 1'b1 >= LeadC) begin // Column lead window
          state_next = refr_reg ? ST_HOLD : ST_COL;
          cnt_next = refr_reg ? cnt_reg + 1'b1 : '0;
        end
      end
      ST_COL: begin
        cnt_next = cnt_reg + 1'b1;
        // Column width and access time both met
        if (cnt_reg + 1'b1 >= ColC && cnt_reg + 1'b1 + LeadC >= AccC) begin
          if (!wr_reg && !dummy_reg) begin
            rdValid_next = 1'b1;
            rdData_next = memDout & memDoutOe; // Open pin reads 0
          end
          dummy_next = 1'b0; // Dummy cycle done
          state_next = ST_PRECH;
          cnt_next = '0;
        end
      end
      ST_HOLD: begin
        // Row-only refresh keeps row strobe up for minimum width
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg + 1'b1 >= AccC) begin
          state_next = ST_PRECH;
          cnt_next = '0;
        end
      end
      ST_PRECH: begin
        // Row precharge and float time before next cycle
        // Precharge ends once RowPrechC and OffC are both met
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg + 1'b1 >= RowPrechC && cnt_reg + 1'b1 >= OffC) begin
          state_next = ST_IDLE;
          cnt_next = '0;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
      refCnt_reg <= '0;
      refRow_reg <= '0;
      addr_reg <= '0;
      wr_reg <= 1'b0;
      din_reg <= 1'b0;
      refr_reg <= 1'b0;
      dummy_reg <= 1'b1; // First cycle uses both strobes
      rdValid_reg <= 1'b0;
      rdData_reg <= 1'b0;
    end else if (clkEn) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      refCnt_reg <= refCnt_next;
      refRow_reg <= refRow_next;
      addr_reg <= addr_next;
      wr_reg <= wr_next;
      din_reg <= din_next;
      refr_reg <= refr_next;
      dummy_reg <= dummy_next;
      rdValid_reg <= rdValid_next;
      rdData_reg <= rdData_next;
    end
  end

  // Pin drive: row half while row strobe rises, column half after
  always_comb begin
    rowStrobe = (state_reg == ST_ROW) || (state_reg == ST_COL) ||
                (state_reg == ST_HOLD);
    colStrobeN = (state_reg != ST_COL);
    // Write low for the whole column strobe
    writeN = !((state_reg == ST_COL) && wr_reg);
    chipSelN = refr_reg; // Deselect in refresh
    memAddr = (state_reg == ST_COL) ? addr_reg[HalfWidth-1:0]
                                    : addr_reg[AddrWidth-1:HalfWidth];
    memDin = din_reg;
    reqReady = (state_reg == ST_IDLE) && (refCnt_reg != GapC);
    rdValid = rdValid_reg;
    rdData = rdData_reg;
  end

  // Row strobe width and spacing counters for assertions
  always_comb begin
    rowCnt_next = rowStrobe ? rowCnt_reg + 1'b1 : '0;
    if (rowStrobe && rowCnt_reg == '0) begin
      sinceRise_next = CntWidth'(1); // First cycle of a new strobe
    end else if (sinceRise_reg >= CycC) begin
      sinceRise_next = sinceRise_reg; // Saturate once the gap is long enough
    end else begin
      sinceRise_next = sinceRise_reg + 1'b1;
    end
  end

  // Monitor registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rowCnt_reg <= '0;
      sinceRise_reg <= CycC;
    end else if (clkEn) begin
      rowCnt_reg <= rowCnt_next;
      sinceRise_reg <= sinceRise_next;
    end
  end

  rowMax_a: assert property (@(posedge sys_clk) disable iff (rst)
    rowCnt_reg <= CntWidth'(RowMaxCyc))
    else $error("row strobe held too long");
  rowMin_a: assert property (@(posedge sys_clk) disable iff (rst)
    clkEn && $fell(rowStrobe) |-> $past(rowCnt_reg) + 1 >= AccC)
    else $error("row strobe too short");
  prech_a: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(rowStrobe) |=> !rowStrobe)
    else $error("row precharge too short");
  colLead_a: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(colStrobeN) |-> $past(rowStrobe) && rowStrobe)
    else $error("column strobe without row lead");
  colWidth_a: assert property (@(posedge sys_clk) disable iff(rst)
    clkEn && $fell(colStrobeN) ##1 clkEn |-> !colStrobeN)
    else $error("column strobe too short");
  wrInCol_a: assert property (@(posedge sys_clk) disable iff (rst)
    !writeN |-> !colStrobeN && rowStrobe)
    else $error("write outside column strobe");
  refSel_a: assert property (@(posedge sys_clk) disable iff (rst)
    rowStrobe && colStrobeN && state_reg == ST_HOLD |-> chipSelN)
    else $error("refresh with chip selected");
  rdPulse_a: assert property (@(posedge sys_clk) disable iff (rst)
    rdValid && clkEn |=> !rdValid)
    else $error("read valid longer than one cycle");
  cycTime_a: assert property (@(posedge sys_clk) disable iff (rst)
    rowStrobe && rowCnt_reg == '0 |-> sinceRise_reg >= CycC)
    else $error("memory cycles too close together");
  wrLead_a: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(colStrobeN) && !$past(writeN) |-> !$past(writeN, WriteCyc))
    else $error("write command too late before column end");
endmodule

// ### rtl/dram_ctrl_pkg.sv
package dram_ctrl_pkg;
  localparam int ClkPeriodNs = 100;
  localparam int AddrWidth = 12;
  localparam int HalfWidth = 6;
  localparam int RowCount = 64;
  // Slower grade figures, ns
  localparam int TCycleNs = 500;
  localparam int TRowAccessNs = 350;
  localparam int TRowPrechNs = 150;
  localparam int TRowWidthNs = 350;
  localparam int TRowMaxNs = 10000;
  localparam int TLeadMinNs = 100;
  localparam int TLeadMaxNs = 150;
  localparam int TColWidthNs = 200;
  localparam int TWriteNs = 150;
  localparam int TOffNs = 100;
  localparam int TRefreshNs = 2000000;
  // Cycle counts: minimum times round up, maximum times round down
  localparam int RowPrechCyc = (TRowPrechNs + ClkPeriodNs - 1) / ClkPeriodNs;
  localparam int LeadCyc = (TLeadMinNs + ClkPeriodNs - 1) / ClkPeriodNs;
  localparam int ColWidthCyc = (TColWidthNs + ClkPeriodNs - 1) / ClkPeriodNs;
  localparam int WriteCyc = (TWriteNs + ClkPeriodNs - 1) / ClkPeriodNs;
  localparam int AccessCyc = (TRowAccessNs + ClkPeriodNs - 1) / ClkPeriodNs;
  localparam int OffCyc = (TOffNs + ClkPeriodNs - 1) / ClkPeriodNs;
  localparam int CycleCyc = (TCycleNs + ClkPeriodNs - 1) / ClkPeriodNs;
  localparam int RowMaxCyc = TRowMaxNs / ClkPeriodNs;
  localparam int RefreshCyc = TRefreshNs / ClkPeriodNs;
  // Refresh spacing: 64 rows spread over the period with margin
  localparam int RefreshGapDefault = RefreshCyc / RowCount / 2;
endpackage

// ### test/dram_ctrl_tb.sv
`timescale 1ns/10ps
module dram_ctrl_tb;
  import dram_ctrl_pkg::*;
  localparam int Gap = 50;
  logic sys_clk, rst, clkEn, reqValid, reqReady, reqWrite, reqData;
  logic rdValid, rdData, rowStrobe, colStrobeN, writeN, chipSelN, memDin;
  logic memDout, memDoutOe, jitter, enAtEdge;
  logic [AddrWidth-1:0] reqAddr, a;
  logic [HalfWidth-1:0] memAddr;
  logic expQ [$];
  logic shadow [logic [AddrWidth-1:0]];
  int num_errors, n_compared, cycles, seed;
  dram_ctrl #(.RefreshGap(Gap)) dram_ctrl_i (.sys_clk(sys_clk), .rst(rst),
    .clkEn(clkEn), .reqValid(reqValid), .reqReady(reqReady),
    .reqWrite(reqWrite), .reqAddr(reqAddr), .reqData(reqData),
    .rdValid(rdValid), .rdData(rdData), .rowStrobe(rowStrobe),
    .colStrobeN(colStrobeN), .writeN(writeN), .chipSelN(chipSelN),
    .memAddr(memAddr), .memDin(memDin), .memDout(memDout),
    .memDoutOe(memDoutOe));
  dram_mem_model #(.RetainNs(1.0 * Gap * RowCount * 2 * ClkPeriodNs))
    dram_mem_model_i (.rowStrobe(rowStrobe), .colStrobeN(colStrobeN),
    .writeN(writeN), .chipSelN(chipSelN), .memAddr(memAddr),
    .memDin(memDin), .memDout(memDout), .memDoutOe(memDoutOe));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic check(input string what, input logic seen, input logic exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("Compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // One cycle; clock enable may stall the design
  task automatic step();
    @(negedge sys_clk);
    clkEn = !jitter || ($random(seed) % 3 != 0);
  endtask
  // Hold a request until taken; note the expected outcome
  task automatic access(input logic wr, input logic [AddrWidth-1:0] ad,
                        input logic d, input bit note);
    reqValid = 1'b1;
    reqWrite = wr;
    reqAddr = ad;
    reqData = d;
    while (!(reqReady === 1'b1 && clkEn === 1'b1)) step();
    if (note && wr) shadow[ad] = d;
    if (note && !wr) expQ.push_back(shadow[ad]);
    step();
  endtask
  // Results: a new rdValid only after an enabled edge
  always @(posedge sys_clk) begin
    enAtEdge <= clkEn;
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      report_and_stop();
    end
  end
  always @(negedge sys_clk) begin
    if (rdValid === 1'b1 && enAtEdge === 1'b1) begin
      if (expQ.size() == 0) check("spurious rdValid", 1'b1, 1'b0);
      else check("rdData", rdData, expQ.pop_front());
    end
  end
  initial begin
    seed = 78;
    cycles = 0;
    jitter = 1'b0;
    rst = 1'b1;
    clkEn = 1'b1;
    reqValid = 1'b0;
    reqWrite = 1'b0;
    reqAddr = 12'h000;
    reqData = 1'b0;
    repeat (3) @(posedge sys_clk);
    step();
    rst = 1'b0;
    access(1'b1, 12'h000, 1'b1, 1'b0);
    // Corner addresses, then random, written back to back
    for (int i = 0; i < 24; i++) begin
      a = i == 0 ? 12'h000 : i == 1 ? 12'hfff : i == 2 ? 12'h03f :
          i == 3 ? 12'hfc0 : 12'($random(seed));
      access(1'b1, a, 1'($random(seed)), 1'b1);
    end
    foreach (shadow[k]) access(1'b0, k, 1'b0, 1'b1);
    // Stalled clock: write then read the same word at once
    jitter = 1'b1;
    for (int i = 0; i < 20; i++) begin
      a = 12'($random(seed));
      access(1'b1, a, 1'($random(seed)), 1'b1);
      access(1'b0, a, 1'b0, 1'b1);
    end
    jitter = 1'b0;
    reqValid = 1'b0;
    // Idle past retention; refresh must keep every row
    repeat (8000) step();
    foreach (shadow[k]) access(1'b0, k, 1'b0, 1'b1);
    reqValid = 1'b0;
    repeat (20) step();
    check("reads pending", expQ.size() == 0, 1'b1);
    report_and_stop();
  end
endmodule

// ### test/dram_mem_model.sv
`timescale 1ns/10ps
module dram_mem_model
  import dram_ctrl_pkg::*;
#(
  parameter real RetainNs = 640000.0,
  parameter real ColAccessNs = 200.0
) (
  // Strobes and address
  input wire logic rowStrobe,
  input wire logic colStrobeN,
  input wire logic writeN,
  input wire logic chipSelN,
  input wire logic [HalfWidth-1:0] memAddr,
  // Data
  input wire logic memDin,
  output logic memDout,
  output logic memDoutOe
);
  logic cells [0:4095];
  logic [HalfWidth-1:0] rowLat;
  logic outVal;
  realtime rowTime;
  realtime dly;
  realtime lastRef [0:RowCount-1];
  initial begin
    memDout = 1'b0;
    memDoutOe = 1'b0;
    foreach (lastRef[r]) lastRef[r] = 0.0;
  end
  // Row latch; a row left too long loses its cells
  always @(posedge rowStrobe) begin
    rowTime = $realtime;
    #1; // Pins launched on the strobe's own edge settle first
    rowLat = memAddr;
    if ($realtime - lastRef[rowLat] > RetainNs) begin
      for (int c = 0; c < 64; c++) begin
        cells[{rowLat, c[5:0]}] = ~cells[{rowLat, c[5:0]}];
      end
    end
    lastRef[rowLat] = $realtime;
  end
  // Column strobe closes output, writes or reads, then opens output
  always @(negedge colStrobeN) begin
    memDoutOe = 1'b0;
    memDout = ~memDout;
    #1; // Write command and column half settle first
    if (rowStrobe && !chipSelN) begin
      if (!writeN) begin
        cells[{rowLat, memAddr}] = memDin;
        outVal = 1'b1;
      end else
        outVal = cells[{rowLat, memAddr}];
      dly = rowTime + TRowAccessNs - $realtime;
      if (dly < ColAccessNs) dly = ColAccessNs;
      #(dly);
      memDout = outVal;
      memDoutOe = 1'b1;
    end
  end
endmodule
